// [rtl/clkgen_ctrl.sv]
// Clock generator control: PLL settings, lock and limp-home status, clock source selection and dividers.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module clkgen_ctrl
	import clkgen_pkg::*;
#(
	parameter int MULT_W   = 6,
	parameter int REFDIV_W = 3,
	parameter int SLOW_W   = 6
) (
	// Clock and reset.
	input  wire logic                clk,
	input  wire logic                nrst,
	// Register port.
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [7:0]          reg_rdata,
	// Mode inputs from the system.
	input  wire logic                test_mode,
	input  wire logic                special_mode,
	input  wire logic                cpu_stop,
	// Analog loop and oscillator status pins.
	input  wire logic                ref_lost_pin,
	input  wire logic                lock_pin,
	input  wire logic                track_pin,
	// Source clock enables.
	input  wire logic                crystal_tick,
	input  wire logic                vco_tick,
	// Analog loop controls.
	output logic      [MULT_W-1:0]   synth_mult,
	output logic      [REFDIV_W-1:0] synth_refdiv,
	output logic                     pll_power_on,
	output logic                     loop_low_bw,
	output logic                     osc_enable,
	output logic                     monitor_reset,
	// Interrupt requests.
	output logic                     lock_irq,
	output logic                     limp_irq,
	// Derived clock enables.
	output logic                     system_tick,
	output logic                     slow_tick,
	output logic                     e_bus_tick,
	output logic                     periph_tick,
	output logic                     slow_derived_tick,
	output logic                     module_tick,
	output logic                     debug_tick,
	output logic                     cpu_stall
);
	typedef enum logic [1:0] {ST_RUN, ST_OLD, ST_NEW} sw_type;

	logic              rs1_q, rst_q;
	logic [2:0]        sy1_q, sy2_q;
	logic [MULT_W-1:0] mult_q;
	logic [REFDIV_W-1:0] refdiv_q;
	logic [SLOW_W-1:0] slow_q, scnt_q;
	logic lock_ie_q, pll_on_q, auto_q, acq_q, pseudo_stop_enable_q, limp_ie_q, no_limp_q, no_limp_wr_q;
	logic bus_src_pll_sel_q, bus_src_slow_sel_q, mcs_q;
	logic lock_flag_q, limp_flag_q, lock_prev_q, limp_prev_q;
	logic slvl_q, sys_half_q, slw_half_q, vco_half_q, xtal_half_q;
	logic rd_q;
	logic [7:0] raddr_q;
	logic limp, lock_stat, track, wr_flags, sys_raw, sel_bus_src_pll_sel;
	src_type cur_q, nxt_q, target;
	sw_type  sw_q;

	// Asynchronous assertion, synchronous release of reset.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rs1_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rst_q <= rs1_q;
		end
	end

	// Pin inputs pass two flip-flops: reference lost, lock detector, tracking.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk or negedge rst_q) begin
				if (!rst_q) begin
					sy1_q[gi] <= 1'b0;
					sy2_q[gi] <= 1'b0;
				end else begin
					sy1_q[gi] <= gi == 0 ? ref_lost_pin : (gi == 1 ? lock_pin : track_pin);
					sy2_q[gi] <= sy1_q[gi];
				end
			end
		end
	endgenerate

	assign limp          = sy2_q[0] & ~no_limp_q;
	assign monitor_reset = sy2_q[0] & no_limp_q;
	assign lock_stat     = sy2_q[1] & pll_power_on & ~limp;
	assign track         = sy2_q[2] & pll_power_on & ~limp;
	assign wr_flags      = reg_wr && reg_addr == OFF_FLAGS;
	assign sel_bus_src_pll_sel      = bus_src_pll_sel_q | limp;

	// Analog loop settings; the PLL itself realises the frequency ratio.
	assign synth_mult   = mult_q;
	assign synth_refdiv = refdiv_q;
	assign pll_power_on = pll_on_q | limp;
	assign loop_low_bw  = auto_q ? track : acq_q;
	assign osc_enable   = ~cpu_stop | pseudo_stop_enable_q;
	assign lock_irq     = lock_flag_q & lock_ie_q;
	assign limp_irq     = limp_flag_q & limp_ie_q;
	assign cpu_stall    = sw_q != ST_RUN;

	// Multiplier and divider are frozen while the PLL select bit is set; limp mode alone does not freeze them.
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			mult_q   <= RST_MULT;
			refdiv_q <= RST_REFDIV;
		end else if (reg_wr && !bus_src_pll_sel_q) begin
			if (reg_addr == OFF_MULT)
				mult_q <= reg_wdata[MULT_W-1:0];
			if (reg_addr == OFF_REFDIV)
				refdiv_q <= reg_wdata[REFDIV_W-1:0];
		end
	end

	// Control register.
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			lock_ie_q    <= 1'b0;
			pll_on_q     <= RST_PLL_ON;
			auto_q       <= RST_AUTO;
			acq_q        <= 1'b0;
			pseudo_stop_enable_q       <= 1'b0;
			limp_ie_q    <= 1'b0;
			no_limp_q    <= RST_NO_LIMP;
			no_limp_wr_q <= 1'b0;
		end else if (reg_wr && reg_addr == OFF_CONTROL) begin
			lock_ie_q <= reg_wdata[CTL_LOCK_IE];
			pll_on_q  <= reg_wdata[CTL_PLL_ON] | bus_src_pll_sel_q;
			auto_q    <= reg_wdata[CTL_AUTO];
			if (!auto_q)
				acq_q <= reg_wdata[CTL_ACQ];
			pseudo_stop_enable_q    <= reg_wdata[CTL_PSEUDO_STOP_ENABLE];
			limp_ie_q <= reg_wdata[CTL_LIMP_IE];
			if (special_mode || !no_limp_wr_q) begin
				no_limp_q    <= reg_wdata[CTL_NO_LIMP];
				no_limp_wr_q <= 1'b1;
			end
		end
	end

	// Clock select and slow divider registers.
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			bus_src_pll_sel_q <= 1'b0;
			bus_src_slow_sel_q <= 1'b0;
			mcs_q  <= 1'b0;
			slow_q <= RST_SLOW;
		end else if (reg_wr) begin
			if (reg_addr == OFF_CLOCK_SOURCE_SELECT) begin
				bus_src_pll_sel_q <= reg_wdata[SEL_PLL] & pll_on_q;
				bus_src_slow_sel_q <= reg_wdata[SEL_SLOW];
				mcs_q  <= reg_wdata[SEL_MODULE];
			end
			if (reg_addr == OFF_SLOW)
				slow_q <= reg_wdata[SLOW_W-1:0];
		end
	end

	// Change flags: a status change in the same cycle as a clear wins.
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			lock_prev_q <= 1'b0;
			limp_prev_q <= 1'b0;
			lock_flag_q <= 1'b0;
			limp_flag_q <= 1'b0;
		end else begin
			lock_prev_q <= lock_stat;
			limp_prev_q <= limp;
			if (limp)
				lock_flag_q <= 1'b0;
			else if (lock_stat != lock_prev_q)
				lock_flag_q <= 1'b1;
			else if (wr_flags && reg_wdata[FLG_LOCK_CHG])
				lock_flag_q <= 1'b0;
			if (limp != limp_prev_q)
				limp_flag_q <= 1'b1;
			else if (wr_flags && reg_wdata[FLG_LIMP_CHG])
				limp_flag_q <= 1'b0;
		end
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			rd_q    <= 1'b0;
			raddr_q <= 8'h00;
		end else begin
			rd_q    <= reg_rd;
			raddr_q <= reg_addr;
		end
	end

	always_comb begin
		reg_rdata = 8'h00;
		if (rd_q) begin
			case (raddr_q)
				OFF_MULT:    reg_rdata = 8'(mult_q);
				OFF_REFDIV:  reg_rdata = 8'(refdiv_q);
				OFF_TEST:    reg_rdata = 8'h00;
				OFF_FLAGS: begin
					reg_rdata[FLG_LOCK_CHG] = lock_flag_q;
					reg_rdata[FLG_LOCK]     = lock_stat;
					reg_rdata[FLG_LIMP_CHG] = limp_flag_q;
					reg_rdata[FLG_LIMP]     = limp;
				end
				OFF_CONTROL: begin
					reg_rdata[CTL_LOCK_IE] = lock_ie_q;
					reg_rdata[CTL_PLL_ON]  = pll_on_q;
					reg_rdata[CTL_AUTO]    = auto_q;
					reg_rdata[CTL_ACQ]     = auto_q ? track : acq_q;
					reg_rdata[CTL_PSEUDO_STOP_ENABLE]    = pseudo_stop_enable_q;
					reg_rdata[CTL_LIMP_IE] = limp_ie_q;
					reg_rdata[CTL_NO_LIMP] = no_limp_q;
				end
				OFF_CLOCK_SOURCE_SELECT: begin
					reg_rdata[SEL_PLL]    = bus_src_pll_sel_q;
					reg_rdata[SEL_SLOW]   = bus_src_slow_sel_q;
					reg_rdata[SEL_MODULE] = mcs_q;
				end
				OFF_SLOW:    reg_rdata = 8'(slow_q);
				default:     reg_rdata = 8'h00;
			endcase
		end
	end

	// Slow divider: the level toggles every slow_q crystal ticks for an even duty.
	// Comparing with >= lets a smaller new divider act at once.
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			scnt_q <= '0;
			slvl_q <= 1'b0;
		end else if (crystal_tick) begin
			if (slow_q == '0 || scnt_q + 1'b1 >= slow_q) begin
				scnt_q <= '0;
				slvl_q <= ~slvl_q;
			end else
				scnt_q <= scnt_q + 1'b1;
		end
	end

	always_comb begin
		if (slow_q == '0)
			slow_tick = crystal_tick;
		else
			slow_tick = crystal_tick && !slvl_q && (scnt_q + 1'b1 >= slow_q);
	end

	function automatic logic src_tick(input src_type s);
		case (s)
			SRC_SLOW:  src_tick = slow_tick;
			SRC_SYNTH: src_tick = vco_tick;
			default:   src_tick = crystal_tick;
		endcase
	endfunction

	assign target = sel_bus_src_pll_sel ? SRC_SYNTH : (bus_src_slow_sel_q ? SRC_SLOW : SRC_XTAL);

	// Source switch waits for an edge of the old clock, then of the new one.
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			sw_q  <= ST_RUN;
			cur_q <= SRC_XTAL;
			nxt_q <= SRC_XTAL;
		end else begin
			case (sw_q)
				ST_RUN:
					if (target != cur_q) begin
						nxt_q <= target;
						sw_q  <= ST_OLD;
					end
				ST_OLD:
					if (src_tick(cur_q))
						sw_q <= ST_NEW;
				ST_NEW:
					if (src_tick(nxt_q)) begin
						cur_q <= nxt_q;
						sw_q  <= ST_RUN;
					end
				default:
					sw_q <= ST_RUN;
			endcase
		end
	end

	assign sys_raw = sw_q == ST_RUN && src_tick(cur_q);

	// Derived clock enables other than slow_tick, all registered.
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			system_tick       <= 1'b0;
			e_bus_tick        <= 1'b0;
			periph_tick       <= 1'b0;
			slow_derived_tick <= 1'b0;
			module_tick       <= 1'b0;
			debug_tick        <= 1'b0;
			sys_half_q        <= 1'b0;
			slw_half_q        <= 1'b0;
			vco_half_q        <= 1'b0;
			xtal_half_q       <= 1'b0;
		end else begin
			system_tick <= sys_raw;
			if (system_tick)
				sys_half_q <= ~sys_half_q;
			if (slow_tick)
				slw_half_q <= ~slw_half_q;
			if (vco_tick)
				vco_half_q <= ~vco_half_q;
			if (crystal_tick)
				xtal_half_q <= ~xtal_half_q;
			e_bus_tick  <= system_tick & sys_half_q;
			periph_tick <= system_tick & sys_half_q;
			slow_derived_tick <= limp ? vco_tick & vco_half_q
				: slow_tick & slw_half_q;
			module_tick <= (mcs_q & ~limp) ? (limp ? 1'b0 : slow_tick & slw_half_q)
				: system_tick & sys_half_q;
			if (limp || (bus_src_slow_sel_q && !bus_src_pll_sel_q && slow_q != '0))
				debug_tick <= system_tick & sys_half_q;
			else
				debug_tick <= crystal_tick & xtal_half_q;
		end
	end

	chk_mult_frozen: assert property (@(posedge clk) disable iff (!rst_q)
		reg_wr && reg_addr == OFF_MULT && bus_src_pll_sel_q |=> $stable(mult_q))
		else $error("multiplier changed while PLL drives the bus");
	chk_test_zero: assert property (@(posedge clk) disable iff (!rst_q)
		reg_rd && reg_addr == OFF_TEST |=> reg_rdata == 8'h00)
		else $error("test register read not zero");
	chk_lock_flag_limp: assert property (@(posedge clk) disable iff (!rst_q)
		limp |=> !lock_flag_q)
		else $error("lock change flag set during limp");
	chk_lock_limp_zero: assert property (@(posedge clk) disable iff (!rst_q)
		limp |-> !lock_stat)
		else $error("lock status high in limp");
	chk_limp_flag_set: assert property (@(posedge clk) disable iff (!rst_q)
		limp != limp_prev_q |=> limp_flag_q)
		else $error("limp change flag missed");
	chk_irq_gating: assert property (@(posedge clk) disable iff (!rst_q)
		(lock_irq |-> lock_ie_q) and (limp_irq |-> limp_ie_q))
		else $error("interrupt without enable");
	chk_pll_on_hold: assert property (@(posedge clk) disable iff (!rst_q)
		reg_wr && reg_addr == OFF_CONTROL && bus_src_pll_sel_q |=> pll_on_q)
		else $error("PLL switched off while selected");
	chk_bus_src_pll_sel_refuse: assert property (@(posedge clk) disable iff (!rst_q)
		reg_wr && reg_addr == OFF_CLOCK_SOURCE_SELECT && !pll_on_q |=> !bus_src_pll_sel_q)
		else $error("PLL selected while off");
	chk_switch_quiet: assert property (@(posedge clk) disable iff (!rst_q)
		sw_q != ST_RUN |=> !system_tick)
		else $error("system clock pulsed during switch");
endmodule : clkgen_ctrl

// [inc/clkgen_pkg.sv]
// Register map, field positions and reset values of the clock generator control block.
package clkgen_pkg;
	localparam logic [7:0] OFF_MULT     = 8'h38;
	localparam logic [7:0] OFF_REFDIV   = 8'h39;
	localparam logic [7:0] OFF_TEST     = 8'h3A;
	localparam logic [7:0] OFF_FLAGS    = 8'h3B;
	localparam logic [7:0] OFF_CONTROL  = 8'h3C;
	localparam logic [7:0] OFF_CLOCK_SOURCE_SELECT   = 8'h3D;
	localparam logic [7:0] OFF_SLOW     = 8'h3E;
	// Flag register bits.
	localparam int FLG_LOCK_CHG = 7;
	localparam int FLG_LOCK     = 6;
	localparam int FLG_LIMP_CHG = 1;
	localparam int FLG_LIMP     = 0;
	// Control register bits.
	localparam int CTL_LOCK_IE  = 7;
	localparam int CTL_PLL_ON   = 6;
	localparam int CTL_AUTO     = 5;
	localparam int CTL_ACQ      = 4;
	localparam int CTL_PSEUDO_STOP_ENABLE     = 2;
	localparam int CTL_LIMP_IE  = 1;
	localparam int CTL_NO_LIMP  = 0;
	// Clock select register bits.
	localparam int SEL_PLL      = 6;
	localparam int SEL_SLOW     = 5;
	localparam int SEL_MODULE   = 2;
	// Reset values.
	localparam logic [5:0] RST_MULT    = 6'h00;
	localparam logic [2:0] RST_REFDIV  = 3'h0;
	localparam logic [5:0] RST_SLOW    = 6'h00;
	localparam logic       RST_PLL_ON  = 1'b1;
	localparam logic       RST_AUTO    = 1'b1;
	localparam logic       RST_NO_LIMP = 1'b0;
	typedef enum logic [1:0] {SRC_XTAL, SRC_SLOW, SRC_SYNTH} src_type;
endpackage : clkgen_pkg

// [verif/clkgen_ctrl_bench.sv]
// Self-checking testbench for the clock generator control block.
`timescale 1ns/1ps
module clkgen_ctrl_bench;
	import clkgen_pkg::*;
	logic       clk;
	logic       nrst;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       test_mode, special_mode, cpu_stop;
	logic       ref_lost_pin, lock_pin, track_pin;
	logic       crystal_tick, vco_tick;
	logic [5:0] synth_mult;
	logic [2:0] synth_refdiv;
	logic       pll_power_on, loop_low_bw, osc_enable, monitor_reset, lock_irq, limp_irq;
	logic       system_tick, slow_tick, e_bus_tick, periph_tick, slow_derived_tick, module_tick, debug_tick;
	logic       cpu_stall;
	logic       gen_on;
	int         num_errors;
	int         total_checks;
	int         cycles;
	logic [7:0] rv, v;
	logic [7:0] rst_exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00};

	clkgen_ctrl uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .test_mode(test_mode), .special_mode(special_mode),
		.cpu_stop(cpu_stop), .ref_lost_pin(ref_lost_pin), .lock_pin(lock_pin), .track_pin(track_pin),
		.crystal_tick(crystal_tick), .vco_tick(vco_tick), .synth_mult(synth_mult), .synth_refdiv(synth_refdiv),
		.pll_power_on(pll_power_on), .loop_low_bw(loop_low_bw), .osc_enable(osc_enable),
		.monitor_reset(monitor_reset), .lock_irq(lock_irq), .limp_irq(limp_irq), .system_tick(system_tick),
		.slow_tick(slow_tick), .e_bus_tick(e_bus_tick), .periph_tick(periph_tick),
		.slow_derived_tick(slow_derived_tick), .module_tick(module_tick), .debug_tick(debug_tick),
		.cpu_stall(cpu_stall));

	always #2 clk = ~clk;

	// Source clock edges arrive at random so that switches see uneven spacing.
	always @(posedge clk) begin
		if (gen_on) begin
			crystal_tick <= 1'($urandom % 2);
			vco_tick     <= 1'($urandom % 2);
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// Pins pass a two-stage synchroniser, so a few cycles are allowed before looking.
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask : settle

	// Waits for a source switch to stall the processor and then release it.
	task automatic wait_switch();
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 200; i++) begin
			@(posedge clk);
			#1;
			if (cpu_stall === 1'b1) seen = 1'b1;
			else if (seen) break;
		end
		check({7'h00, seen}, 8'h01);
		check({7'h00, cpu_stall}, 8'h00);
	endtask : wait_switch

	initial begin
		clk = 1'b0; nrst = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
		test_mode = 1'b0; special_mode = 1'b0; cpu_stop = 1'b0; ref_lost_pin = 1'b0; lock_pin = 1'b0;
		track_pin = 1'b0; crystal_tick = 1'b0; vco_tick = 1'b0; gen_on = 1'b0;
		num_errors = 0; total_checks = 0; cycles = 0;
		void'($urandom(32'h217f));
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		gen_on <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rd(OFF_MULT + 8'(i), rv);
			check(rv, rst_exp[i]);
		end
		wr(OFF_TEST, 8'hFF);
		rd(OFF_TEST, rv);
		check(rv, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			wr(OFF_MULT, v);
			wr(OFF_REFDIV, v);
			wr(OFF_SLOW, v);
			rd(OFF_MULT, rv);
			check(rv, v & 8'h3F);
			check({2'h0, synth_mult}, v & 8'h3F);
			rd(OFF_REFDIV, rv);
			check({5'h00, synth_refdiv}, v & 8'h07);
			rd(OFF_SLOW, rv);
			check(rv, v & 8'h3F);
		end
		wr(OFF_MULT, 8'h05);
		wr(OFF_REFDIV, 8'h02);
		wr(OFF_CLOCK_SOURCE_SELECT, 8'h40);
		wait_switch();
		wr(OFF_MULT, 8'h15);
		wr(OFF_REFDIV, 8'h07);
		rd(OFF_MULT, rv);
		check(rv, 8'h05);
		rd(OFF_REFDIV, rv);
		check(rv, 8'h02);
		wr(OFF_CONTROL, 8'h20);
		rd(OFF_CONTROL, rv);
		check(rv, 8'h60);
		wr(OFF_CLOCK_SOURCE_SELECT, 8'h00);
		wait_switch();
		wr(OFF_CONTROL, 8'h00);
		wr(OFF_CLOCK_SOURCE_SELECT, 8'h40);
		rd(OFF_CLOCK_SOURCE_SELECT, rv);
		check(rv, 8'h00);
		wr(OFF_CONTROL, 8'h10);
		#1;
		check({7'h00, loop_low_bw}, 8'h01);
		wr(OFF_CONTROL, 8'h04);
		cpu_stop <= 1'b1;
		@(posedge clk);
		#1;
		check({7'h00, osc_enable}, 8'h01);
		wr(OFF_CONTROL, 8'h00);
		#1;
		check({6'h00, loop_low_bw, osc_enable}, 8'h00);
		cpu_stop <= 1'b0;
		// The no-limp bit is already spent by the earlier writes, so this one must bounce.
		wr(OFF_CONTROL, 8'h01);
		rd(OFF_CONTROL, rv);
		check(rv, 8'h00);
		// Lock only reports while the loop is powered, so the PLL is switched on beside the enable.
		wr(OFF_CONTROL, 8'hC0);
		lock_pin <= 1'b1;
		settle();
		rd(OFF_FLAGS, rv);
		check(rv, 8'hC0);
		check({7'h00, lock_irq}, 8'h01);
		wr(OFF_FLAGS, 8'hFF);
		rd(OFF_FLAGS, rv);
		check(rv, 8'h40);
		lock_pin <= 1'b0;
		settle();
		rd(OFF_FLAGS, rv);
		check(rv, 8'h80);
		wr(OFF_CONTROL, 8'h00);
		#1;
		check({7'h00, lock_irq}, 8'h00);
		wr(OFF_FLAGS, 8'h80);
		wr(OFF_CLOCK_SOURCE_SELECT, 8'h04);
		wr(OFF_CONTROL, 8'h02);
		ref_lost_pin <= 1'b1;
		lock_pin <= 1'b1;
		settle();
		rd(OFF_FLAGS, rv);
		check(rv, 8'h03);
		check({6'h00, limp_irq, pll_power_on}, 8'h03);
		rd(OFF_CONTROL, rv);
		check(rv, 8'h02);
		rd(OFF_CLOCK_SOURCE_SELECT, rv);
		check(rv, 8'h04);
		wr(OFF_FLAGS, 8'h02);
		rd(OFF_FLAGS, rv);
		check(rv, 8'h01);
		ref_lost_pin <= 1'b0;
		lock_pin <= 1'b0;
		settle();
		rd(OFF_FLAGS, rv);
		check(rv & 8'h03, 8'h02);
		check({7'h00, pll_power_on}, 8'h00);
		wr(OFF_FLAGS, 8'hFF);
		special_mode <= 1'b1;
		wr(OFF_CONTROL, 8'h01);
		rd(OFF_CONTROL, rv);
		check(rv, 8'h01);
		ref_lost_pin <= 1'b1;
		settle();
		check({7'h00, monitor_reset}, 8'h01);
		rd(OFF_FLAGS, rv);
		check(rv & 8'h01, 8'h00);
		ref_lost_pin <= 1'b0;
		wr(OFF_SLOW, 8'h00);
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			#1;
			check({7'h00, slow_tick}, {7'h00, crystal_tick});
		end
		wr(OFF_CLOCK_SOURCE_SELECT, 8'h20);
		wait_switch();
		rd(OFF_CLOCK_SOURCE_SELECT, rv);
		check(rv, 8'h20);
		wr(OFF_CLOCK_SOURCE_SELECT, 8'h00);
		wait_switch();
		rd(8'h40, rv);
		check(rv, 8'h00);
		end_of_test();
	end
endmodule : clkgen_ctrl_bench
